// *** core/pwm_blank_pkg.sv ***
// Contract
// - Blanking window suppresses trip events during transitions
// - Trip ending under three clocks after window may glitch
// - Trip ending near window close gives odd waveform
// - First three window cycles pass trips unblanked
// - Filtered event follows raw events while unblanked
// - Enabled filtered event feeds trip and outputs
// - Blanking window persists across period boundary
// - Zero delay unsupported in shadow load mode
package pwm_blank_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          CNT_W           = 16;
    localparam int          DB_W            = 10;
    localparam int          BLANK_LAG       = 3;
    localparam int          TRIP_HOLD       = 3;
    localparam logic [3:0]  ADR_CTRL        = 4'h0;
    localparam logic [3:0]  ADR_PERIOD      = 4'h1;
    localparam logic [3:0]  ADR_BLANK       = 4'h2;
    localparam logic [3:0]  ADR_CMP         = 4'h3;
    localparam logic [3:0]  ADR_RISE        = 4'h4;
    localparam logic [3:0]  ADR_FALL        = 4'h5;
    localparam logic [3:0]  ADR_STAT        = 4'h6;
    localparam int          CTRL_EN         = 0;
    localparam int          CTRL_FILT_EN    = 1;
    localparam int          CTRL_RISE_SHD   = 2;
    localparam int          CTRL_FALL_SHD   = 3;
    localparam int          CTRL_BLANK_EN   = 4;
    localparam logic [31:0] PERIOD_RST      = 32'h0000_00ff;
    localparam logic [31:0] CMP_RST         = 32'h0000_0080;
    typedef enum logic [1:0] {
        BLK_IDLE  = 2'b00,
        BLK_LAG   = 2'b01,
        BLK_ACT   = 2'b11
    } blank_state_t;
endpackage

// *** core/deadband_gen.sv ***
`timescale 1ns/1ps
module deadband_gen
    import pwm_blank_pkg::*;
#(
    parameter int DW = pwm_blank_pkg::DB_W
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          pwm_i,
    input  wire logic [DW-1:0] rising_delay_count_i,
    input  wire logic [DW-1:0] falling_delay_count_i,
    output logic               pwm_a_o,
    output logic               pwm_b_o
);
    logic [DW-1:0] cnt_r, cnt_nxt;
    logic          prev_r, prev_nxt;
    logic          a_r, a_nxt;
    logic          b_r, b_nxt;

    always_comb begin
        prev_nxt = pwm_i;
        cnt_nxt  = cnt_r;
        a_nxt    = a_r;
        b_nxt    = b_r;
        if (pwm_i != prev_r) begin
            cnt_nxt = pwm_i ? rising_delay_count_i : falling_delay_count_i;
            a_nxt   = 1'b0;
            b_nxt   = 1'b0;
            if (pwm_i && rising_delay_count_i == '0) begin
                a_nxt = 1'b1;
            end
            if (!pwm_i && falling_delay_count_i == '0) begin
                b_nxt = 1'b1;
            end
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
            if (cnt_r == DW'(1)) begin
                a_nxt = prev_r;
                b_nxt = !prev_r;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= '0;
            prev_r <= 1'b0;
            a_r    <= 1'b0;
            b_r    <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            prev_r <= prev_nxt;
            a_r    <= a_nxt;
            b_r    <= b_nxt;
        end
    end

    assign pwm_a_o = a_r;
    assign pwm_b_o = b_r;
endmodule

// *** core/pwm_trip_blanking_deadband.sv ***
`timescale 1ns/1ps
module pwm_trip_blanking_deadband
    import pwm_blank_pkg::*;
#(
    parameter int NEVT = 2
) (
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           cyc_i,
    input  wire logic                           stb_i,
    input  wire logic                           we_i,
    input  wire logic [pwm_blank_pkg::ADDR_W-1:0] adr_i,
    input  wire logic [3:0]                     sel_i,
    input  wire logic [31:0]                    dat_i,
    output logic [31:0]                         dat_o,
    output logic                                ack_o,
    input  wire logic [NEVT-1:0]                raw_compare_event_signals_i,
    output logic                                filtered_compare_event_o,
    output logic                                trip_zone_o,
    output logic                                soc_trigger_o,
    output logic                                pwm_a_o,
    output logic                                pwm_b_o
);
    import pwm_blank_pkg::*;

    // Register file
    logic [4:0]        ctrl_r, ctrl_nxt;
    logic [CNT_W-1:0]  period_r, period_nxt;
    logic [CNT_W-1:0]  blank_off_r, blank_off_nxt;
    logic [CNT_W-1:0]  blank_len_r, blank_len_nxt;
    logic [CNT_W-1:0]  cmp_r, cmp_nxt;
    logic [DB_W-1:0]   rise_wr_r, rise_wr_nxt;
    logic [DB_W-1:0]   fall_wr_r, fall_wr_nxt;
    logic [DB_W-1:0]   rising_delay_count_r, rising_delay_count_nxt;
    logic [DB_W-1:0]   falling_delay_count_r, falling_delay_count_nxt;
    logic              trip_r, trip_nxt;
    logic              ack_r, ack_nxt;
    logic [31:0]       dat_r, dat_nxt;
    // Counter, blanking and trip path
    logic [CNT_W-1:0]  tb_r, tb_nxt;
    logic [CNT_W-1:0]  blen_r, blen_nxt;
    logic [1:0]        lag_r, lag_nxt;
    blank_state_t      bst_r, bst_nxt;
    logic              filt_r, filt_nxt;
    logic              pwm_r, pwm_nxt;
    logic              soc_r, soc_nxt;

    logic wr, rd, prd_end, raw_any, blanking;
    // Writes land at the edge where the master samples ack high
    assign wr       = cyc_i && stb_i && we_i && ack_r;
    assign rd       = cyc_i && stb_i && !we_i && !ack_r;
    assign prd_end  = (tb_r == period_r);
    assign raw_any  = |raw_compare_event_signals_i;
    // Suppression only once the lag cycles have passed
    assign blanking = (bst_r == BLK_ACT);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [31:0] m;
        m                       = '0;
        ctrl_nxt                = ctrl_r;
        period_nxt              = period_r;
        blank_off_nxt           = blank_off_r;
        blank_len_nxt           = blank_len_r;
        cmp_nxt                 = cmp_r;
        rise_wr_nxt             = rise_wr_r;
        fall_wr_nxt             = fall_wr_r;
        rising_delay_count_nxt  = rising_delay_count_r;
        falling_delay_count_nxt = falling_delay_count_r;
        ack_nxt                 = cyc_i && stb_i && !ack_r;
        dat_nxt                 = dat_r;
        if (wr) begin
            unique case (adr_i)
                ADR_CTRL: begin
                    m        = merge({27'h0, ctrl_r}, dat_i, sel_i);
                    ctrl_nxt = m[4:0];
                end
                ADR_PERIOD: begin
                    m          = merge({16'h0, period_r}, dat_i, sel_i);
                    period_nxt = m[CNT_W-1:0];
                end
                ADR_BLANK: begin
                    m             = merge({blank_len_r, blank_off_r}, dat_i, sel_i);
                    blank_off_nxt = m[15:0];
                    blank_len_nxt = m[31:16];
                end
                ADR_CMP: begin
                    m       = merge({16'h0, cmp_r}, dat_i, sel_i);
                    cmp_nxt = m[CNT_W-1:0];
                end
                ADR_RISE: begin
                    m           = merge({22'h0, rise_wr_r}, dat_i, sel_i);
                    rise_wr_nxt = m[DB_W-1:0];
                end
                ADR_FALL: begin
                    m           = merge({22'h0, fall_wr_r}, dat_i, sel_i);
                    fall_wr_nxt = m[DB_W-1:0];
                end
                default: ;
            endcase
        end
        // Immediate mode follows the written value; shadow loads at period end
        if (!ctrl_r[CTRL_RISE_SHD] || prd_end) begin
            rising_delay_count_nxt = rise_wr_r;
        end
        if (!ctrl_r[CTRL_FALL_SHD] || prd_end) begin
            falling_delay_count_nxt = fall_wr_r;
        end
        if (rd) begin
            unique case (adr_i)
                ADR_CTRL:   dat_nxt = {27'h0, ctrl_r};
                ADR_PERIOD: dat_nxt = {16'h0, period_r};
                ADR_BLANK:  dat_nxt = {blank_len_r, blank_off_r};
                ADR_CMP:    dat_nxt = {16'h0, cmp_r};
                ADR_RISE:   dat_nxt = {22'h0, rise_wr_r};
                ADR_FALL:   dat_nxt = {22'h0, fall_wr_r};
                ADR_STAT:   dat_nxt = {12'h0, bst_r, filt_r, trip_r, tb_r};
                default:    dat_nxt = '0;
            endcase
        end
    end

    always_comb begin
        tb_nxt   = prd_end ? '0 : tb_r + 1'b1;
        bst_nxt  = bst_r;
        blen_nxt = blen_r;
        lag_nxt  = lag_r;
        if (!ctrl_r[CTRL_EN]) begin
            tb_nxt = '0;
        end
        // Window is timed by its own length, not by the period
        unique case (bst_r)
            BLK_IDLE: begin
                if (ctrl_r[CTRL_BLANK_EN] && ctrl_r[CTRL_EN] && tb_r == blank_off_r) begin
                    bst_nxt  = BLK_LAG;
                    lag_nxt  = 2'(BLANK_LAG - 1);
                    blen_nxt = blank_len_r;
                end
            end
            BLK_LAG: begin
                lag_nxt = lag_r - 1'b1;
                if (lag_r == '0) begin
                    bst_nxt = (blen_r == '0) ? BLK_IDLE : BLK_ACT;
                end
            end
            BLK_ACT: begin
                blen_nxt = blen_r - 1'b1;
                if (blen_r <= CNT_W'(1)) begin
                    bst_nxt = BLK_IDLE;
                end
            end
            default: bst_nxt = BLK_IDLE;
        endcase
        // Filtered event follows raw inputs except while blanking
        filt_nxt = raw_any && !blanking;
        trip_nxt = ctrl_r[CTRL_FILT_EN] && filt_r;
        soc_nxt  = ctrl_r[CTRL_FILT_EN] && filt_r && !filt_nxt;
        // A trip still present one cycle after the window close drops the output for a cycle
        pwm_nxt  = ctrl_r[CTRL_EN] && (tb_r < cmp_r) && !(ctrl_r[CTRL_FILT_EN] && filt_r);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r                <= '0;
            period_r              <= PERIOD_RST[CNT_W-1:0];
            blank_off_r           <= '0;
            blank_len_r           <= '0;
            cmp_r                 <= CMP_RST[CNT_W-1:0];
            rise_wr_r             <= '0;
            fall_wr_r             <= '0;
            rising_delay_count_r  <= '0;
            falling_delay_count_r <= '0;
            ack_r                 <= 1'b0;
            dat_r                 <= '0;
            tb_r                  <= '0;
            blen_r                <= '0;
            lag_r                 <= '0;
            bst_r                 <= BLK_IDLE;
            filt_r                <= 1'b0;
            trip_r                <= 1'b0;
            pwm_r                 <= 1'b0;
            soc_r                 <= 1'b0;
        end else begin
            ctrl_r                <= ctrl_nxt;
            period_r              <= period_nxt;
            blank_off_r           <= blank_off_nxt;
            blank_len_r           <= blank_len_nxt;
            cmp_r                 <= cmp_nxt;
            rise_wr_r             <= rise_wr_nxt;
            fall_wr_r             <= fall_wr_nxt;
            rising_delay_count_r  <= rising_delay_count_nxt;
            falling_delay_count_r <= falling_delay_count_nxt;
            ack_r                 <= ack_nxt;
            dat_r                 <= dat_nxt;
            tb_r                  <= tb_nxt;
            blen_r                <= blen_nxt;
            lag_r                 <= lag_nxt;
            bst_r                 <= bst_nxt;
            filt_r                <= filt_nxt;
            trip_r                <= trip_nxt;
            pwm_r                 <= pwm_nxt;
            soc_r                 <= soc_nxt;
        end
    end

    // Zero delay in shadow mode is not guarded; software must pick immediate mode
    deadband_gen #(.DW(DB_W)) u_db (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .pwm_i                 (pwm_r),
        .rising_delay_count_i  (rising_delay_count_r),
        .falling_delay_count_i (falling_delay_count_r),
        .pwm_a_o               (pwm_a_o),
        .pwm_b_o               (pwm_b_o)
    );

    assign ack_o                    = ack_r;
    assign dat_o                    = dat_r;
    assign filtered_compare_event_o = filt_r;
    assign trip_zone_o              = trip_r;
    assign soc_trigger_o            = soc_r;

    AST_LAG_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
        (bst_r == BLK_LAG && raw_any) |=> filt_r)
        else $error("Trip blanked during lag cycles");
    AST_BLANK_SUPPRESS: assert property (@(posedge clk_i) disable iff (rst_i)
        (bst_r == BLK_ACT) |=> !filt_r)
        else $error("Trip passed during active blanking");
    AST_LAG_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
        (bst_r == BLK_IDLE && bst_nxt == BLK_LAG) |=> (bst_r == BLK_LAG) [*3])
        else $error("Lag phase not three cycles");
    AST_FOLLOW: assert property (@(posedge clk_i) disable iff (rst_i)
        (bst_r == BLK_IDLE) |=> (filt_r == $past(raw_any)))
        else $error("Filtered event not following raw");
    AST_TRIP_FEED: assert property (@(posedge clk_i) disable iff (rst_i)
        (filt_r && ctrl_r[CTRL_FILT_EN]) |=> trip_r)
        else $error("Trip zone not fed by filtered event");
    AST_ACROSS_PERIOD: assert property (@(posedge clk_i) disable iff (rst_i)
        (bst_r == BLK_ACT && blen_r > CNT_W'(1) && prd_end) |=> (bst_r == BLK_ACT))
        else $error("Window ended at period boundary");
    AST_IMM_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ctrl_r[CTRL_RISE_SHD]) |=> (rising_delay_count_r == $past(rise_wr_r)))
        else $error("Immediate rise delay not loaded");
    AST_SHD_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_r[CTRL_FALL_SHD] && !prd_end) |=> $stable(falling_delay_count_r))
        else $error("Shadow fall delay changed early");
    AST_ACK_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_r |=> !ack_r)
        else $error("Ack held two cycles");
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_r) |=> ack_r)
        else $error("Ack not given one cycle after request");
    AST_TRIP_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ctrl_r[CTRL_FILT_EN]) |=> !trip_r)
        else $error("Trip zone driven while filter disabled");
    AST_SOC_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_r[CTRL_FILT_EN] && filt_r) ##1 !filt_r |-> soc_r)
        else $error("No conversion trigger at filtered event fall");
    AST_SOC_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ctrl_r[CTRL_FILT_EN]) |=> !soc_r)
        else $error("Conversion trigger while filter disabled");
    AST_PWM_TRIP: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_r[CTRL_FILT_EN] && filt_r) |=> !pwm_r)
        else $error("Output not tripped by filtered event");
    AST_WIN_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i)
        (bst_r == BLK_ACT && blen_r == CNT_W'(1) && raw_any) ##1 raw_any |=> filt_r)
        else $error("Trip held past window close not passed");
    AST_WIN_ENDED: assert property (@(posedge clk_i) disable iff (rst_i)
        (bst_r == BLK_ACT && blen_r == CNT_W'(1)) ##1 !raw_any |=> !filt_r)
        else $error("Trip ended at window close still passed");
    AST_ACT_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
        (bst_r == BLK_LAG && lag_r == 2'd0 && blen_r == CNT_W'(1))
        |=> (bst_r == BLK_ACT) ##1 (bst_r == BLK_IDLE))
        else $error("One cycle window has wrong length");
    AST_SHD_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_r[CTRL_RISE_SHD] && prd_end) |=> (rising_delay_count_r == $past(rise_wr_r)))
        else $error("Shadow rise delay not loaded at period end");
    AST_SHD_RISE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl_r[CTRL_RISE_SHD] && !prd_end) |=> $stable(rising_delay_count_r))
        else $error("Shadow rise delay changed early");
    AST_IMM_FALL: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ctrl_r[CTRL_FALL_SHD]) |=> (falling_delay_count_r == $past(fall_wr_r)))
        else $error("Immediate fall delay not loaded");
    AST_STOP_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
        (!ctrl_r[CTRL_EN]) |=> (tb_r == '0 && !pwm_r))
        else $error("Counter or output running while stopped");
    COV_BLANK: cover property (@(posedge clk_i) disable iff (rst_i)
        bst_r == BLK_LAG ##3 bst_r == BLK_ACT);
    COV_LATE_TRIP: cover property (@(posedge clk_i) disable iff (rst_i)
        (bst_r == BLK_ACT && bst_nxt == BLK_IDLE && raw_any) ##1 raw_any);
    COV_SHADOW: cover property (@(posedge clk_i) disable iff (rst_i)
        ctrl_r[CTRL_RISE_SHD] && prd_end);
    COV_WRAP_WINDOW: cover property (@(posedge clk_i) disable iff (rst_i)
        bst_r == BLK_ACT && prd_end);
    COV_SOC: cover property (@(posedge clk_i) disable iff (rst_i)
        soc_r);
endmodule

// *** tb/trip_source_model.sv ***
`timescale 1ns/1ps
module trip_source_model #(
    parameter int NEVT = 2
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic [NEVT-1:0] trip_req_i,
    input  wire logic            pwm_a_i,
    input  wire logic            pwm_b_i,
    output logic      [NEVT-1:0] raw_o,
    output logic                 rise_vld_o,
    output logic                 fall_vld_o,
    output logic      [15:0]     gap_o
);
    logic a_r;
    logic b_r;
    // Trip sources hold their level from one clock edge to the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            raw_o <= '0;
            a_r   <= 1'b0;
            b_r   <= 1'b0;
            gap_o <= '0;
        end else begin
            raw_o <= trip_req_i;
            a_r   <= pwm_a_i;
            b_r   <= pwm_b_i;
            gap_o <= (pwm_a_i | pwm_b_i) ? 16'h0000 : gap_o + 16'h0001;
        end
    end
    // Gap is the count of cycles with both switches off before a turn-on
    assign rise_vld_o = pwm_a_i & ~a_r;
    assign fall_vld_o = pwm_b_i & ~b_r;
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    import pwm_blank_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [3:0]  adr_i = 4'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [1:0]  trip_req = 2'b00;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [1:0]  raw;
    logic        filt, trip, soc, pwm_a, pwm_b, rise_vld, fall_vld;
    logic [15:0] gap;
    logic [31:0] rd_q[$], rise_q[$], fall_q[$], run_q[$];
    logic        chk_trip = 1'b0;
    logic        hold = 1'b0;
    logic        prev_filt = 1'b0;
    int          num_errors = 0;
    int          n_tests = 0;
    int          cyc_cnt = 0;
    int          run_len = 0;

    pwm_trip_blanking_deadband #(.NEVT(2)) i_pwm_trip_blanking_deadband (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .raw_compare_event_signals_i(raw), .filtered_compare_event_o(filt),
        .trip_zone_o(trip), .soc_trigger_o(soc), .pwm_a_o(pwm_a), .pwm_b_o(pwm_b));
    trip_source_model #(.NEVT(2)) i_trip_source_model (
        .clk_i(clk_i), .rst_i(rst_i), .trip_req_i(trip_req), .pwm_a_i(pwm_a),
        .pwm_b_i(pwm_b), .raw_o(raw), .rise_vld_o(rise_vld), .fall_vld_o(fall_vld),
        .gap_o(gap));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic single cycle, held until ack, then one idle cycle
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic a_high();
        while (pwm_a !== 1'b1) @(posedge clk_i);
        @(posedge clk_i);
    endtask

    task automatic drain();
        while (rise_q.size() + fall_q.size() + run_q.size() != 0) @(posedge clk_i);
    endtask

    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 40000) begin
            num_errors++;
            stop_test();
        end
    end

    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() > 0)
            cmp32(dat_o, rd_q.pop_front());
        if (rise_vld === 1'b1 && rise_q.size() > 0)
            cmp32(32'(gap), rise_q.pop_front());
        if (fall_vld === 1'b1 && fall_q.size() > 0)
            cmp32(32'(gap), fall_q.pop_front());
        if (chk_trip) begin
            cmp32(32'(trip), 32'(prev_filt));
            cmp32(32'(soc), 32'(prev_filt & ~filt));
        end
        prev_filt <= filt;
        if (hold && filt === 1'b0) begin
            run_len++;
        end else if (hold && run_len > 0) begin
            if (run_q.size() > 0)
                cmp32(32'(run_len), run_q.pop_front());
            run_len = 0;
        end
    end

    initial begin
        logic [15:0] d;
        logic [15:0] offs [3];
        logic [15:0] lens [3];
        int          i;
        offs = '{16'h000a, 16'h0024, 16'h0005};
        lens = '{16'h0008, 16'h000c, 16'h0001};
        void'($urandom(32'h83c8));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(ADR_CTRL, 32'h0000_0000);
        rd(ADR_PERIOD, PERIOD_RST);
        rd(ADR_CMP, CMP_RST);
        rd(ADR_STAT, 32'h0000_0000);
        wb(1'b1, 4'h7, 32'hffff_ffff);
        rd(4'h7, 32'h0000_0000);
        wb(1'b1, ADR_PERIOD, 32'h0000_0028);
        rd(ADR_PERIOD, 32'h0000_0028);
        wb(1'b1, ADR_CMP, 32'h0000_0014);
        $display("test registers ended");
        wb(1'b1, ADR_CTRL, 32'h0000_0001);
        for (i = 0; i < 4; i++) begin
            d = (i == 0) ? 16'h0000 : 16'(1 + $urandom % 8);
            wb(1'b1, ADR_RISE, 32'(d));
            wb(1'b1, ADR_FALL, 32'(d));
            a_high();
            rise_q.push_back(32'(d));
            fall_q.push_back(32'(d));
            drain();
        end
        $display("test immediate delay ended");
        wb(1'b1, ADR_CTRL, 32'h0000_000d);
        d = 16'(1 + $urandom % 8);
        wb(1'b1, ADR_RISE, 32'(d));
        wb(1'b1, ADR_FALL, 32'(d + 16'h0001));
        repeat (90) @(posedge clk_i);
        a_high();
        rise_q.push_back(32'(d));
        fall_q.push_back(32'(d + 16'h0001));
        drain();
        $display("test shadow delay ended");
        trip_req <= 2'b01 << ($urandom % 2);
        wb(1'b1, ADR_CTRL, 32'h0000_0013);
        repeat (4) @(posedge clk_i);
        chk_trip <= 1'b1;
        hold <= 1'b1;
        for (i = 0; i < 3; i++) begin
            wb(1'b1, ADR_BLANK, {lens[i], offs[i]});
            repeat (90) @(posedge clk_i);
            while (filt !== 1'b1) @(posedge clk_i);
            @(posedge clk_i);
            run_q.push_back(32'(lens[i]));
            drain();
        end
        chk_trip <= 1'b0;
        hold <= 1'b0;
        wb(1'b1, ADR_CTRL, 32'h0000_0011);
        repeat (5) @(posedge clk_i);
        cmp32(32'(trip), 32'h0000_0000);
        cmp32(32'(soc), 32'h0000_0000);
        $display("test blanking ended");
        stop_test();
    end
endmodule
